// >>> blec_top.sv
/*
 Boot loader entry and exit control with password gate and serial route.
 Assumes pins are asynchronous, raw levels; loader firmware supplies
 password values and the serial byte stream.
 Assumes the supply and image flags, the passwords and the transmit bit
 come from logic on mclk, so they are read without synchronisers.
 Assumes a core-domain entry detector outside this block reports its
 sequence as a level on core_entry_seen.
*/
`timescale 1ns/1ps
`include "blec_cfg.svh"
module blec_top #(
	parameter int PW_BITS = `BLEC_PW_BITS
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire blec_pkg::blec_pins_t  pins,
	input  wire logic                  loader_enable_pulled,
	input  wire logic                  io_supply_rail_ok,
	input  wire logic                  io_image_loaded,
	input  wire logic                  core_entry_seen,
	input  wire logic [PW_BITS-1:0]    user_password,
	input  wire logic [PW_BITS-1:0]    host_password,
	input  wire logic                  host_password_valid,
	input  wire logic                  serial_tx_data,
	output logic                       port3_bit3_tx,
	output logic                       port3_bit3_oe,
	output logic                       loader_rx_data,
	output blec_pkg::blec_status_t     status
);
	import blec_pkg::*;

	// Settle counter width and the cycle count at which enable is sampled
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(`BLEC_SAMPLE_CYC);

	// Serial route decode, shared by the data path and the pin enable
	function automatic logic io_route_on(
		input blec_state_t s,
		input logic        m,
		input logic        sup
	);
		// Route only in the I/O loader with its supply present
		return (s == blec_loader) && m && sup;
	endfunction

	// Pin synchronisers
	blec_pins_t            sync1;         // First stage, only read by sync2
	blec_pins_t            sync2;         // Synchronised pins
	logic                  enable_sync1;  // Pulled enable first stage
	logic                  enable_sync2;  // Pulled enable synchronised
	// Sequencer state
	blec_state_t           state;         // Sequencer state
	blec_state_t           next_state;
	logic [CNT_W-1:0]      cnt;           // Settle counter
	logic [CNT_W-1:0]      next_cnt;
	logic                  io_mode;       // Loader entered via I/O pins
	logic                  next_io_mode;
	logic                  granted;       // Password accepted
	logic                  next_granted;
	// Serial route registers
	logic                  tx;            // Registered transmit data
	logic                  next_tx;
	logic                  rx;            // Registered receive data
	logic                  next_rx;
	// Combinational decodes
	logic                  any_reset;     // Either reset pin low
	logic                  io_path_ok;    // I/O loader interface usable

	// Two-flop synchronisers on all pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Reset pins read as asserted until real samples arrive
			sync1        <= '0;
			sync2        <= '0;
			enable_sync1 <= 1'b0;
			enable_sync2 <= 1'b0;
		end else begin
			// Shift raw levels through two stages
			sync1        <= pins;
			sync2        <= sync1;
			enable_sync1 <= loader_enable_pulled;
			enable_sync2 <= enable_sync1;
		end
	end

	// Reset from either pin
	// Both pins are read only after their second stage
	assign any_reset = !sync2.core_domain_reset_pin_n || !sync2.io_domain_reset_pin_n;
	// I/O path needs the supply and the loaded image
	// Without either, entry falls back to core or normal start
	assign io_path_ok = io_supply_rail_ok && io_image_loaded;

	// Next-state logic for the sequencer
	always_comb begin
		// Hold every value unless a branch moves it
		next_state   = state;
		next_cnt     = cnt;
		next_io_mode = io_mode;
		next_granted = granted;
		case (state)
			blec_held: begin
				// Wait for both resets released
				next_granted = 1'b0;
				next_cnt     = '0;
				if (!any_reset) begin
					next_state = blec_settle;
				end
			end
			blec_settle: begin
				// Count out the settle time, then sample enable once
				if (any_reset) begin
					next_state = blec_held;
				end else if (cnt == SAMPLE_CYC - CNT_W'(1)) begin
					// Undriven enable reads low through pulldown
					if (enable_sync2 && io_path_ok) begin
						next_state   = blec_loader;
						next_io_mode = 1'b1;
					end else if (core_entry_seen) begin
						// Core-domain sequence took the loader instead
						next_state   = blec_loader;
						next_io_mode = 1'b0;
					end else begin
						// Enable low or I/O path closed: normal start
						next_state   = blec_normal;
						next_io_mode = 1'b0;
					end
				end else begin
					// Still counting out the settle time
					next_cnt = cnt + CNT_W'(1);
				end
			end
			blec_normal: begin
				// Application runs until next reset
				if (any_reset) begin
					next_state = blec_held;
				end
			end
			blec_loader: begin
				// Enable may drop; only reset or, in I/O mode, loss of the I/O supply leaves this state
				if (any_reset) begin
					next_state = blec_held;
				end else if (host_password_valid &&
					host_password == user_password) begin
					next_granted = 1'b1;
				end
				// Losing the I/O supply closes the I/O loader
				if (io_mode && !io_supply_rail_ok) begin
					next_state = blec_held;
				end
			end
			default: begin
				// Unused codes fall back to held
				next_state = blec_held;
			end
		endcase
	end

	// Serial route next values
	always_comb begin
		// Both lines idle high while the route is closed
		next_tx = 1'b1;
		next_rx = 1'b1;
		if (io_route_on(state, io_mode, io_supply_rail_ok)) begin
			// Transmit bit out on port 3 bit 3, receive bit in from bit 4
			next_tx = serial_tx_data;
			next_rx = sync2.serial_unit_zero_rx;
		end
	end

	// State registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Sequencer starts held, serial lines idle high
			state   <= blec_held;
			cnt     <= '0;
			io_mode <= 1'b0;
			granted <= 1'b0;
			tx      <= 1'b1;
			rx      <= 1'b1;
		end else begin
			// Capture next values
			state   <= next_state;
			cnt     <= next_cnt;
			io_mode <= next_io_mode;
			granted <= next_granted;
			tx      <= next_tx;
			rx      <= next_rx;
		end
	end

	// Serial data pins come straight from their registers
	assign port3_bit3_tx  = tx;
	// Enable drops in the same cycle as the I/O supply flag
	assign port3_bit3_oe  = io_route_on(state, io_mode, io_supply_rail_ok);
	assign loader_rx_data = rx;

	// Status decode from the state register
	always_comb begin
		// Held and settle both keep the device in reset
		status.device_in_reset    = (state == blec_held) || (state == blec_settle);
		status.loader_active      = (state == blec_loader);
		// Loader flavour follows the entry path
		status.io_loader_mode     = (state == blec_loader) && io_mode;
		status.core_loader_mode   = (state == blec_loader) && !io_mode;
		// Memory opens only after a password match in the loader
		status.mem_access_granted = (state == blec_loader) && granted;
	end
endmodule

// >>> blec_cfg.svh
/*
 Constants for the boot loader entry control block.
 Assumes mclk at 125 MHz; included by bare name.
*/
`ifndef BLEC_CFG_SVH
`define BLEC_CFG_SVH
`define BLEC_CLK_MHZ 125
`define BLEC_SAMPLE_NS 800
`define BLEC_SAMPLE_CYC ((`BLEC_SAMPLE_NS * `BLEC_CLK_MHZ + 999) / 1000)
`define BLEC_PW_BITS 32
`define BLEC_PW_RESET 32'h0000_0000
`endif

// >>> blec_pkg.sv
/*
 Types for the boot loader entry control block.
 Assumes blec_cfg.svh defines the constants.
*/
`include "blec_cfg.svh"
package blec_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		blec_held   = 3'b000,
		blec_settle = 3'b001,
		blec_normal = 3'b010,
		blec_loader = 3'b011
	} blec_state_t;
	// Pin samples from the host side
	typedef struct packed {
		logic core_domain_reset_pin_n;
		logic io_domain_reset_pin_n;
		logic loader_enable_pin;
		logic test_select_pin;
		logic serial_unit_zero_rx;
	} blec_pins_t;
	// Status toward the rest of the device
	typedef struct packed {
		logic device_in_reset;
		logic loader_active;
		logic io_loader_mode;
		logic core_loader_mode;
		logic mem_access_granted;
	} blec_status_t;
endpackage

// >>> blec_monitor.sv
/* Port checker for blec_top.
 Assumes a bind by name below. */
`timescale 1ns/1ps
module blec_monitor #(
	parameter int PW_BITS = 32
) (
	input wire logic                 mclk,
	input wire logic                 rst,
	input wire blec_pkg::blec_pins_t pins,
	input wire logic                 io_supply_rail_ok,
	input wire logic                 io_image_loaded,
	input wire logic [PW_BITS-1:0]   user_password,
	input wire logic [PW_BITS-1:0]   host_password,
	input wire logic                 host_password_valid,
	input wire logic                 port3_bit3_oe,
	input wire blec_pkg::blec_status_t status
);
	import blec_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	rst_hold_a: assert property (disable iff (1'b0) rst |=> status.device_in_reset)
		else $error("reset not held");
	io_pin_a: assert property (!pins.io_domain_reset_pin_n |-> ##[1:3] status.device_in_reset)
		else $error("io pin reset missed");
	core_pin_a: assert property (!pins.core_domain_reset_pin_n |-> ##[1:3] status.device_in_reset)
		else $error("core pin reset missed");
	tx_gate_a: assert property (port3_bit3_oe |-> status.io_loader_mode)
		else $error("tx driven outside io mode");
	supply_gate_a: assert property (status.io_loader_mode |-> $past(io_supply_rail_ok))
		else $error("io mode without io supply");
	image_gate_a: assert property ($rose(status.io_loader_mode) |-> $past(io_image_loaded))
		else $error("io mode without image");
	grant_mode_a: assert property (status.mem_access_granted |-> status.loader_active)
		else $error("grant outside loader");
	grant_pw_a: assert property ($rose(status.mem_access_granted) |->
		$past(host_password_valid) && $past(host_password) == $past(user_password))
		else $error("grant without password");
	mode_stands_a: assert property (status.loader_active && pins.io_domain_reset_pin_n &&
		pins.core_domain_reset_pin_n && io_supply_rail_ok |=> status.loader_active)
		else $error("loader left without reset");
	io_cov: cover property (status.io_loader_mode);
	core_cov: cover property (status.core_loader_mode);
	grant_cov: cover property (status.mem_access_granted);
	supply_cov: cover property (status.io_loader_mode ##1 !status.loader_active);
endmodule
bind blec_top blec_monitor #(.PW_BITS(PW_BITS)) u_blec_monitor (.mclk(mclk), .rst(rst),
	.pins(pins), .io_supply_rail_ok(io_supply_rail_ok), .io_image_loaded(io_image_loaded),
	.user_password(user_password), .host_password(host_password),
	.host_password_valid(host_password_valid), .port3_bit3_oe(port3_bit3_oe), .status(status));

// >>> blec_host.sv
/* Host programmer model driving reset pins, enable and receive line.
 Assumes a free-running mclk. */
`timescale 1ns/1ps
module blec_host (
	input wire logic            mclk,
	output blec_pkg::blec_pins_t pins,
	output logic                loader_enable_pulled
);
	import blec_pkg::*;
	logic en_drv = 1'b0; // Host drive on enable
	logic core_n = 1'b1; // Core reset pin
	logic io_n   = 1'b1; // I/O reset pin
	logic rx     = 1'b1; // UART idles high
	// Released enable reads low through the pulldown
	assign loader_enable_pulled = en_drv;
	assign pins = '{core_n, io_n, en_drv, 1'b0, rx};
	// Reset pin high-low-high with enable driven to en, then enable released
	task automatic seq(input logic en);
		en_drv <= en;
		repeat (2) @(posedge mclk);
		io_n <= 1'b0;
		repeat (4) @(posedge mclk);
		io_n <= 1'b1;
		repeat (120) @(posedge mclk);
		en_drv <= 1'b0;
		// One edge before the next call may drive the enable again
		@(posedge mclk);
	endtask
endmodule

// >>> blec_top_tb.sv
/* Self-checking bench for blec_top.
 Assumes the host model drives the pins. */
`timescale 1ns/1ps
module blec_top_tb;
	import blec_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, sup = 1'b1, img = 1'b1, cseen = 1'b0, pw_ok = 1'b0, tx = 1'b1;
	logic [31:0] upw = 32'h1234_5678, hpw = 32'h0000_0000;
	logic oe, rxd, txd, en;
	blec_pins_t pins;
	blec_status_t st;
	int num_errors = 0, checks_done = 0;
	initial forever #4 mclk = ~mclk;
	blec_host u_blec_host (.mclk(mclk), .pins(pins), .loader_enable_pulled(en));
	blec_top u_blec_top (.mclk(mclk), .rst(rst), .pins(pins), .loader_enable_pulled(en),
		.io_supply_rail_ok(sup), .io_image_loaded(img), .core_entry_seen(cseen),
		.user_password(upw), .host_password(hpw), .host_password_valid(pw_ok),
		.serial_tx_data(tx), .port3_bit3_tx(txd), .port3_bit3_oe(oe), .loader_rx_data(rxd),
		.status(st));
	task automatic chk(input string n, input logic s, input logic e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_entry();
		u_blec_host.seq(1'b1);
		chk("io_mode", st.io_loader_mode, 1'b1);
		chk("oe", oe, 1'b1);
		tx <= 1'b0;
		u_blec_host.rx <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("tx", txd, 1'b0);
		chk("rx", rxd, 1'b0);
		chk("stay", st.loader_active, 1'b1);
		tx <= 1'b1;
		u_blec_host.rx <= 1'b1;
		hpw <= 32'h1234_5679;
		pw_ok <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("bad_pw", st.mem_access_granted, 1'b0);
		hpw <= upw;
		repeat (3) @(posedge mclk);
		chk("good_pw", st.mem_access_granted, 1'b1);
		pw_ok <= 1'b0;
	endtask
	task automatic t_exit();
		u_blec_host.seq(1'b0);
		chk("exit", st.loader_active, 1'b0);
		chk("grant_clr", st.mem_access_granted, 1'b0);
		chk("run", st.device_in_reset, 1'b0);
	endtask
	task automatic t_refuse();
		img <= 1'b0;
		cseen <= 1'b1;
		u_blec_host.seq(1'b1);
		chk("no_image", st.io_loader_mode, 1'b0);
		chk("core_mode", st.core_loader_mode, 1'b1);
		img <= 1'b1;
		cseen <= 1'b0;
		sup <= 1'b0;
		u_blec_host.seq(1'b1);
		chk("no_supply", st.io_loader_mode, 1'b0);
		chk("no_oe", oe, 1'b0);
		sup <= 1'b1;
		u_blec_host.seq(1'b1);
		chk("io_again", st.io_loader_mode, 1'b1);
		sup <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("sup_lost", st.loader_active, 1'b0);
		chk("sup_oe", oe, 1'b0);
		sup <= 1'b1;
	endtask
	task automatic t_core_rst();
		u_blec_host.core_n <= 1'b0;
		repeat (5) @(posedge mclk);
		chk("core_hold", st.device_in_reset, 1'b1);
		u_blec_host.core_n <= 1'b1;
		repeat (110) @(posedge mclk);
		chk("core_free", st.device_in_reset, 1'b0);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_entry();
		t_exit();
		t_refuse();
		t_core_rst();
		print_verdict();
	end
	initial begin
		#100_000;
		num_errors++;
		print_verdict();
	end
endmodule
